// ### rtl/swrlc_ctrl.sv
/*
  switch control register with reset triggers, write lock release, budget
  value unlock and link-down warm reset inhibit, reached over apb.
  assumes the switch core drives link-down events and consumes the reset
  requests; an apb master that follows the usual setup/access protocol.
*/
// The APB register port is this design's own decision.
// Functional notes
// (R01) writing one to bit 0 starts full reset
// (R02) writing one to bit 1 starts warm reset, retrain
// (R03) completion returned before the reset begins
// (R04) gated fields writable only while release bit set
// (R05) release bit set at power-up and by reset
// (R06) bit 4 gated; opens budget value writes
// (R07) bit 5 blocks link-down warm reset only
// (R08) bit 2 reserved, reads zero
// (R09) sticky bits survive warm reset
// (R10) closed budget unlock discards budget value writes
// (R11) writes to reserved bit have no effect
`timescale 1ns/1ns
`include "swrlc_cfg.svh"

module swrlc_ctrl
  import swrlc_pkg::*;
#(
  parameter int ADDR_W = `SWRLC_ADDR_W
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // switch core side
  input wire logic link_down_evt,
  input wire logic other_warm_evt,
  input wire logic eeprom_load_done,
  output logic full_reset_req,
  output logic warm_reset_req,
  output logic link_retrain_req,
  output logic gated_write_release,
  output logic budget_value_write_open,
  output logic linkdown_warm_reset_inhibit
);

  // refuse an address bus too narrow for the register offset
  initial
  begin
    if (ADDR_W < `SWRLC_ADDR_W)
      $error("swrlc_ctrl: address too narrow");
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // byte lane that holds a given bit position
  function automatic logic lane_on(input logic [3:0] strb, input int bitpos);
    lane_on = strb[bitpos / 8];
  endfunction : lane_on

  // ---------------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------------
  swrlc_state_e st_q; // sequencer state
  swrlc_state_e st_d;
  logic rel_q; // gated write release, set by every reset
  logic budg_q; // budget value unlock, sticky
  logic ldinh_q; // link-down inhibit, sticky
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic full_q;
  logic warm_q;
  logic retrain_q;
  logic tmr_busy;
  logic tmr_done;
  logic full_pend_q; // which reset follows the completion
  logic warm_pend_q;

  wire setup_w = psel && !penable;
  wire hit_w = (paddr[`SWRLC_ADDR_W-1:0] == `SWRLC_OFS_CTRL);
  wire acc_w = psel && penable && pready_q;
  wire wr_w = acc_w && pwrite && hit_w;
  // answer one cycle after the setup cycle
  wire ready_d_w = setup_w;
  wire lane0_w = lane_on(pstrb, `SWRLC_BIT_FULL);
  wire full_wr_w = wr_w && lane0_w && pwdata[`SWRLC_BIT_FULL];
  wire warm_wr_w = wr_w && lane0_w && pwdata[`SWRLC_BIT_WARM];
  // a new trigger is only taken while the sequencer is idle
  wire idle_w = (st_q == SWRLC_IDLE);
  // link-down warm reset, unless inhibited; other causes always act
  // (R07) inhibit link-down cause
  wire ld_warm_w = link_down_evt && !ldinh_q;
  wire hw_warm_w = idle_w && (ld_warm_w || other_warm_evt);
  // (R04) release gates field writes
  wire gated_ok_w = wr_w && lane0_w && rel_q;
  wire plain_ok_w = wr_w && lane0_w;

  // read value: triggers and reserved bit read zero
  // (R01) trigger reads zero
  // (R08) reserved reads zero
  wire [31:0] rd_w = hit_w ? ({26'h0, ldinh_q, budg_q, rel_q, 3'b000}) : 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      SWRLC_IDLE:
      begin
        // (R03) completion first, reset after
        if (full_wr_w || warm_wr_w)
          st_d = SWRLC_CPL;
        else if (hw_warm_w)
          st_d = SWRLC_WARM;
      end
      SWRLC_CPL:
      begin
        // the access phase with pready has ended this cycle
        st_d = full_pend_q ? SWRLC_FULL : SWRLC_WARM;
      end
      SWRLC_FULL:
      begin
        if (tmr_done)
          st_d = SWRLC_IDLE;
      end
      SWRLC_WARM:
      begin
        if (tmr_done)
          st_d = SWRLC_IDLE;
      end
      default:
        st_d = SWRLC_IDLE;
    endcase
  end

  wire start_w = (st_q == SWRLC_CPL) || (idle_w && hw_warm_w && !full_wr_w && !warm_wr_w);

  // pulse length timer
  swrlc_pulse_timer u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(start_w),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // state and pending kind
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= SWRLC_IDLE;
      full_pend_q <= 1'b0;
      warm_pend_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      if (idle_w)
      begin
        // full reset wins when both triggers are written together
        full_pend_q <= full_wr_w;
        warm_pend_q <= warm_wr_w && !full_wr_w;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // reset request outputs
  // ---------------------------------------------------------------------------
  wire full_on_w = (st_d == SWRLC_FULL);
  wire warm_on_w = (st_d == SWRLC_WARM);

  // requests held for the whole timed pulse
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      full_q <= 1'b0;
      warm_q <= 1'b0;
      retrain_q <= 1'b0;
    end
    else
    begin
      // (R01) full reset request
      full_q <= full_on_w;
      // (R02) warm reset plus retrain
      warm_q <= warm_on_w;
      retrain_q <= warm_on_w && (warm_pend_q || (st_q == SWRLC_CPL && !full_pend_q));
    end
  end

  // ---------------------------------------------------------------------------
  // control bits
  // ---------------------------------------------------------------------------
  // release bit: set during any reset so the eeprom load can write gated
  // fields; software or the end of the load clears it afterwards
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      // (R05) release set by reset
      rel_q <= 1'b1;
    else if (full_on_w || warm_on_w)
      rel_q <= 1'b1;
    else if (plain_ok_w)
      rel_q <= pwdata[`SWRLC_BIT_REL];
    else if (eeprom_load_done)
      rel_q <= 1'b0;
  end

  // sticky bits: only the asynchronous fundamental reset clears them
  // (R09) warm reset keeps these
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      budg_q <= 1'b0;
      ldinh_q <= 1'b0;
    end
    else
    begin
      // (R06) budget unlock is gated
      if (gated_ok_w)
        budg_q <= pwdata[`SWRLC_BIT_BUDG];
      if (plain_ok_w)
        ldinh_q <= pwdata[`SWRLC_BIT_LDINH];
    end
  end
  // (R11) bit 2 never stored

  // ---------------------------------------------------------------------------
  // apb answer
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `SWRLC_CTRL_RST;
    end
    else
    begin
      pready_q <= ready_d_w;
      pslverr_q <= ready_d_w && !hit_w;
      prdata_q <= (ready_d_w && !pwrite) ? rd_w : 32'h0000_0000;
    end
  end

  // gated flags feed every port's budget value and lock-gated fields
  // budget values follow their own unlock only; the release bit guards bit 4 itself
  // (R10) closed unlock blocks budget writes
  assign budget_value_write_open = budg_q;
  assign gated_write_release = rel_q;
  assign linkdown_warm_reset_inhibit = ldinh_q;
  assign full_reset_req = full_q;
  assign warm_reset_req = warm_q;
  assign link_retrain_req = retrain_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  sequence s_trig_wr;
    idle_w && (full_wr_w || warm_wr_w);
  endsequence

  AST_CPL_FIRST: assert property (@(posedge sys_clk) disable iff (!rst_n) // R03
    s_trig_wr |-> !full_reset_req && !warm_reset_req ##1 !full_reset_req && !warm_reset_req)
    else $error("reset started before completion");

  AST_FULL_START: assert property (@(posedge sys_clk) disable iff (!rst_n) // R01
    (idle_w && full_wr_w) |-> ##2 full_reset_req)
    else $error("full reset not started");

  AST_WARM_RETRAIN: assert property (@(posedge sys_clk) disable iff (!rst_n) // R02
    (idle_w && warm_wr_w && !full_wr_w) |-> ##2 (warm_reset_req && link_retrain_req))
    else $error("warm reset or retrain missing");

  AST_TRIG_RD_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n) // R08
    pready |-> prdata[2:0] == 3'b000)
    else $error("trigger or reserved bit read nonzero");

  AST_LOCKED_BUDG: assert property (@(posedge sys_clk) disable iff (!rst_n) // R04
    (wr_w && !rel_q) |=> $stable(budg_q))
    else $error("gated bit changed while locked");

  AST_RESET_REL: assert property (@(posedge sys_clk) disable iff (!rst_n) // R05
    warm_reset_req |-> gated_write_release)
    else $error("release not set during reset");

  AST_LD_INHIBIT: assert property (@(posedge sys_clk) disable iff (!rst_n) // R07
    (idle_w && ldinh_q && link_down_evt && !other_warm_evt && !full_wr_w && !warm_wr_w)
      |=> ##1 !warm_reset_req)
    else $error("link-down warm reset not inhibited");

  AST_STICKY: assert property (@(posedge sys_clk) disable iff (!rst_n) // R09
    (warm_reset_req && !wr_w) |=> ($stable(ldinh_q) && $stable(budg_q)))
    else $error("sticky bit lost on warm reset");

  AST_BUDG_OPEN: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
    !budg_q |-> !budget_value_write_open)
    else $error("budget writes open while locked");

  AST_PULSE_TIMED: assert property (@(posedge sys_clk) disable iff (!rst_n) // R01
    (full_reset_req || warm_reset_req) |-> tmr_busy)
    else $error("reset request outside timed pulse");

endmodule : swrlc_ctrl

// ### rtl/swrlc_pulse_timer.sv
/*
  down counter that holds a reset request output for a fixed number of cycles.
  assumes a single clock and an active low asynchronous reset.
*/
`timescale 1ns/1ns
`include "swrlc_cfg.svh"

module swrlc_pulse_timer
  import swrlc_pkg::*;
#(
  parameter int CNT_W = `SWRLC_CNT_W,
  parameter logic [`SWRLC_CNT_W-1:0] LEN = `SWRLC_CNT_W'(`SWRLC_RST_CYC)
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  output logic busy,
  output logic done
);

  // refuse a zero length or a counter under two bits wide
  initial
  begin
    if (CNT_W < 2 || LEN == '0)
      $error("swrlc_pulse_timer: bad length");
  end

  logic [CNT_W-1:0] cnt_q; // remaining cycles
  logic [CNT_W-1:0] cnt_d;
  wire last_w = (cnt_q == CNT_W'(`SWRLC_CNT_ONE));

  assign cnt_d = start ? CNT_W'(LEN) : ((cnt_q != '0) ? cnt_q - CNT_W'(`SWRLC_CNT_ONE) : cnt_q);
  assign busy = (cnt_q != '0);
  assign done = last_w;

  // counter register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

endmodule : swrlc_pulse_timer

// ### shared/swrlc_cfg.svh
/*
  constants for the switch reset and lock control block: register offset,
  field positions, reset values and timing counts.
  assumes it is included by bare name from package and rtl files.
*/
`ifndef SWRLC_CFG_SVH
`define SWRLC_CFG_SVH

// -----------------------------------------------------------------------------
// register map
// -----------------------------------------------------------------------------
`define SWRLC_ADDR_W 12
`define SWRLC_OFS_CTRL 12'h0404
`define SWRLC_CTRL_RST 32'h0000_0000

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define SWRLC_BIT_FULL 0
`define SWRLC_BIT_WARM 1
`define SWRLC_BIT_RSVD 2
`define SWRLC_BIT_REL 3
`define SWRLC_BIT_BUDG 4
`define SWRLC_BIT_LDINH 5

// -----------------------------------------------------------------------------
// timing: reset pulse length in ns and derived cycles at 250 mhz
// -----------------------------------------------------------------------------
`define SWRLC_CLK_MHZ 250
`define SWRLC_RST_PULSE_NS 64
`define SWRLC_RST_CYC ((`SWRLC_RST_PULSE_NS * `SWRLC_CLK_MHZ + 999) / 1000)
`define SWRLC_CNT_W 8
`define SWRLC_CNT_ONE 8'h01

`endif

// ### shared/swrlc_pkg.sv
/*
  types for the switch reset and lock control block.
  assumes swrlc_cfg.svh is on the include path.
*/
`include "swrlc_cfg.svh"

package swrlc_pkg;
  // reset sequencer states, one-hot
  typedef enum logic [3:0] {
    SWRLC_IDLE = 4'b0001,
    SWRLC_CPL = 4'b0010,
    SWRLC_FULL = 4'b0100,
    SWRLC_WARM = 4'b1000
  } swrlc_state_e;
endpackage : swrlc_pkg

// ### verification/swrlc_core_model.sv
/*
  stand-in for the switch core: turns bench commands into link events
  and plays the eeprom loader once a reset pulse has ended.
  assumes the same clock and reset as the control block.
*/
`timescale 1ns/1ns

module swrlc_core_model
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic full_reset_req,
  input wire logic warm_reset_req,
  input wire logic ld_go,
  input wire logic ow_go,
  input wire logic load_en,
  output logic link_down_evt,
  output logic other_warm_evt,
  output logic eeprom_load_done
);
  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic busy_q; // a reset pulse was seen last cycle
  logic [2:0] wait_q; // loader delay, kept short so runs stay brief
  wire rst_any = full_reset_req | warm_reset_req; // either reset request

  // events follow bench commands one cycle later, as a core would register them
  // loader after reset
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_down_evt <= 1'b0;
      other_warm_evt <= 1'b0;
      eeprom_load_done <= 1'b0;
      busy_q <= 1'b0;
      wait_q <= 3'h0;
    end
    else
    begin
      link_down_evt <= ld_go;
      other_warm_evt <= ow_go;
      busy_q <= rst_any;
      eeprom_load_done <= (wait_q == 3'h1);
      // only a falling reset with loading enabled starts the loader
      if (busy_q && !rst_any && load_en)
        wait_q <= 3'h4;
      else if (wait_q != 3'h0)
        wait_q <= wait_q - 3'h1;
    end
  end
endmodule : swrlc_core_model

// ### verification/test_switch_reset_lock_control.sv
/*
  self-checking bench for the switch control register over apb.
  assumes the core stand-in model and the cfg header are compiled first.
*/
`timescale 1ns/1ns
`include "swrlc_cfg.svh"

module test_switch_reset_lock_control;
  // ---------------------------------------------------------------------------
  // stimulus and wiring
  // ---------------------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic ld_go = 1'b0, ow_go = 1'b0, load_en = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, link_down_evt, other_warm_evt, eeprom_load_done;
  logic full_reset_req, warm_reset_req, link_retrain_req;
  logic gated_write_release, budget_value_write_open, linkdown_warm_reset_inhibit;
  wire [2:0] reqs = {link_retrain_req, warm_reset_req, full_reset_req};
  int mismatches = 0;
  int n_checks = 0;
  int plen = `SWRLC_RST_CYC; // expected reset pulse length
  // 250 mhz clock
  always #2 sys_clk = ~sys_clk;

  swrlc_ctrl swrlc_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_down_evt(link_down_evt),
    .other_warm_evt(other_warm_evt), .eeprom_load_done(eeprom_load_done),
    .full_reset_req(full_reset_req), .warm_reset_req(warm_reset_req),
    .link_retrain_req(link_retrain_req), .gated_write_release(gated_write_release),
    .budget_value_write_open(budget_value_write_open),
    .linkdown_warm_reset_inhibit(linkdown_warm_reset_inhibit));
  swrlc_core_model swrlc_core_model_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .full_reset_req(full_reset_req), .warm_reset_req(warm_reset_req), .ld_go(ld_go),
    .ow_go(ow_go), .load_en(load_en), .link_down_evt(link_down_evt),
    .other_warm_evt(other_warm_evt), .eeprom_load_done(eeprom_load_done));

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one apb transfer; pready and the answer are taken at the rising edge that ends it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 20)
      mismatches++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, `SWRLC_OFS_CTRL, d, rd, er);
  endtask : wr

  task automatic rdc(input logic [31:0] e);
    logic [31:0] rd;
    logic er;
    apb(1'b0, `SWRLC_OFS_CTRL, 32'h0000_0000, rd, er);
    chk("ctrl", e, rd);
    chk("err", 32'h0000_0000, {31'h0, er});
  endtask : rdc

  // length of the next pulse on reqs[idx], and retrain cycles inside it
  task automatic meas(input int idx, output int len, output int rlen);
    int n;
    n = 0;
    len = 0;
    rlen = 0;
    @(negedge sys_clk);
    while (reqs[idx] !== 1'b1 && n < 40)
    begin
      @(negedge sys_clk);
      n++;
    end
    while (reqs[idx] === 1'b1 && len < 200)
    begin
      len++;
      if (link_retrain_req === 1'b1)
        rlen++;
      @(negedge sys_clk);
    end
  endtask : meas

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  // software trigger: completion first, then a pulse of the set length
  task automatic t_trig(input logic [31:0] d, input int idx, input int rexp);
    int len, rlen;
    wr(d);
    @(negedge sys_clk);
    chk("req_at_cpl", 32'h0, {29'h0, reqs});
    meas(idx, len, rlen);
    chk("pulse_len", plen, len);
    chk("retrain_len", rexp, rlen);
  endtask : t_trig

  task automatic t_lock;
    wr(32'h0000_0000);
    rdc(32'h0000_0000);
    wr(32'h0000_0010);
    rdc(32'h0000_0000);
    chk("budget_open", 32'h0, {31'h0, budget_value_write_open});
    wr(32'h0000_0008);
    wr(32'h0000_001c);
    rdc(32'h0000_0018);
    chk("budget_open", 32'h1, {31'h0, budget_value_write_open});
    wr(32'h0000_0010);
    rdc(32'h0000_0010);
    chk("budget_open", 32'h1, {31'h0, budget_value_write_open});
  endtask : t_lock

  // link-down cause blocked, other causes still act
  task automatic t_inhibit;
    int len, rlen, seen;
    seen = 0;
    wr(32'h0000_0038);
    chk("inhibit", 32'h1, {31'h0, linkdown_warm_reset_inhibit});
    @(posedge sys_clk);
    ld_go <= 1'b1;
    @(posedge sys_clk);
    ld_go <= 1'b0;
    repeat (30)
    begin
      @(negedge sys_clk);
      if (warm_reset_req !== 1'b0)
        seen++;
    end
    chk("ld_blocked", 32'h0, seen);
    @(posedge sys_clk);
    ow_go <= 1'b1;
    @(posedge sys_clk);
    ow_go <= 1'b0;
    meas(1, len, rlen);
    chk("other_warm", plen, len);
    rdc(32'h0000_0038);
    wr(32'h0000_0018);
    @(posedge sys_clk);
    ld_go <= 1'b1;
    @(posedge sys_clk);
    ld_go <= 1'b0;
    meas(1, len, rlen);
    chk("ld_warm", plen, len);
  endtask : t_inhibit

  task automatic t_release;
    logic [31:0] rd;
    logic er;
    wr(32'h0000_0000);
    t_trig(32'h0000_0002, 1, plen);
    rdc(32'h0000_0008);
    load_en <= 1'b1;
    t_trig(32'h0000_0002, 1, plen);
    repeat (10) @(posedge sys_clk);
    chk("release", 32'h0, {31'h0, gated_write_release});
    apb(1'b0, 12'h400, 32'h0000_0000, rd, er);
    chk("unmapped_err", 32'h1, {31'h0, er});
  endtask : t_release

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge sys_clk);
    chk("rel_in_reset", 32'h1, {31'h0, gated_write_release});
    rst_n <= 1'b1;
    rdc(32'h0000_0008);
    t_lock();
    wr(32'h0000_0038);
    t_trig(32'h0000_003a, 1, plen);
    rdc(32'h0000_0038);
    t_inhibit();
    t_release();
    t_trig(32'h0000_0003, 0, 0);
    report_and_stop();
  end

  // generous bound: the tests take well under 2000 cycles
  initial
  begin
    #40000;
    mismatches++;
    report_and_stop();
  end
endmodule : test_switch_reset_lock_control
